// ===== rtl/sclu_pkg.sv
// constants shared by the current-loop serial block
package sclu_pkg;
  localparam int unsigned CLK_HZ           = 125000000;
  localparam logic [15:0] VEC_RX           = 16'h0020;
  localparam logic [15:0] VEC_TX           = 16'h0028;
  localparam logic [2:0]  IRQ_NUM_RX       = 3'h4;
  localparam logic [2:0]  IRQ_NUM_TX       = 3'h5;
  localparam logic [7:0]  RATE_CODE_RESET  = 8'h00;
  localparam int unsigned RATE_SEL_LSB     = 0;
  localparam int unsigned RATE_SEL_W       = 7;
  localparam int unsigned STOP_SEL_BIT     = 7;
  localparam int unsigned DATA_BITS        = 8;
  localparam logic        LINE_IDLE        = 1'b1;
  localparam logic [1:0]  MASK_RESET       = 2'h0;
  // divisor per bit is (rate field + 1) * BIT_UNIT cycles
  localparam int unsigned BIT_UNIT         = 16;
endpackage

// ===== rtl/sclu_bit_timer.sv
// bit-period counter: divisor from rate field, restartable
`timescale 1ns/1ps
`default_nettype none
module sclu_bit_timer #(
  parameter int unsigned W = 12
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         restart,
  input  wire logic [W-1:0] period,
  output logic              half_tick,
  output logic              full_tick
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  assign full_tick  = (count == period);
  assign half_tick  = (count == {1'b0, period[W-1:1]});
  assign next_count = (restart || full_tick) ? '0 : count + 1'b1;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/sclu_uart.sv
// current-loop serial transmitter and receiver with request latches
// Contract
// - receiver frames by start and stop bits, stores character in holding buffer
// - new received character sets the receive-loaded flag
// - loaded flag requests vector 0020 when unmasked and nothing higher pending
// - reading the receive buffer clears the loaded flag
// - eight-bit rate code picks bit rate and stop-bit count
// - transmit write places character in transmit holding buffer
// - shifter adds start and stop bits, shifts at programmed rate alone
// - empty transmit buffer raises empty flag and requests interrupt
// - transmit request is number 5, vector 0028, below receive number 4
// - request reaches cpu only if mask bit set; latched while masked
`timescale 1ns/1ps
`default_nettype none
module sclu_uart #(
  parameter int unsigned TW = 12
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        write_rate_code,
  input  wire logic        write_transmit_char,
  input  wire logic [7:0]  wr_data,
  input  wire logic        rx_read,
  input  wire logic [1:0]  irq_mask,
  input  wire logic        higher_pending,
  input  wire logic        serial_in_plus,
  output logic             serial_out_plus,
  output logic             serial_out_minus,
  output logic [7:0]       rx_data,
  output logic             rx_loaded,
  output logic             tx_empty,
  output logic             serial_irq,
  output logic [2:0]       irq_num,
  output logic [15:0]      irq_vector,
  output logic [7:0]       rate_code
);
  typedef enum logic [1:0] {SCLU_IDLE, SCLU_START, SCLU_DATA, SCLU_STOP} sclu_state_t;

  localparam int unsigned RATE_SEL_W = sclu_pkg::RATE_SEL_W;
  // period from rate field; limited width keeps divider small
  function automatic logic [TW-1:0] sclu_period(input logic [7:0] code);
    logic [TW-1:0] p;
    p = TW'((32'(code[RATE_SEL_W-1:0]) + 32'd1) * sclu_pkg::BIT_UNIT - 32'd1);
    return p;
  endfunction

  logic [TW-1:0] period;
  logic          two_stops;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rate_code <= sclu_pkg::RATE_CODE_RESET;
    end else if (write_rate_code) begin
      rate_code <= wr_data;
    end
  end
  assign period    = sclu_period(rate_code);
  assign two_stops = rate_code[sclu_pkg::STOP_SEL_BIT];

  // pin input passes two flops before use
  logic rx_meta;
  logic rx_sync;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_meta <= sclu_pkg::LINE_IDLE;
      rx_sync <= sclu_pkg::LINE_IDLE;
    end else begin
      rx_meta <= serial_in_plus;
      rx_sync <= rx_meta;
    end
  end

  // ---------------- receiver
  sclu_state_t rx_state;
  logic [2:0]  rx_bit;
  logic [7:0]  rx_shift;
  logic        rx_half;
  logic        rx_full;
  logic        rx_restart;
  logic        rx_done;

  // restart on start edge so half tick lands mid start bit
  assign rx_restart = (rx_state == SCLU_IDLE) && !rx_sync;
  sclu_bit_timer #(.W(TW)) u_rx_timer (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .restart   (rx_restart),
    .period    (period),
    .half_tick (rx_half),
    .full_tick (rx_full)
  );

  // samples happen at half ticks, i.e. centre of each bit
  // start/stop framing
  assign rx_done = (rx_state == SCLU_STOP) && rx_half && rx_sync;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_state <= SCLU_IDLE;
      rx_bit   <= 3'h0;
      rx_shift <= 8'h00;
    end else begin
      case (rx_state)
        SCLU_IDLE: begin
          if (!rx_sync) begin
            rx_state <= SCLU_START;
          end
        end
        SCLU_START: begin
          // glitch shorter than half a bit is dropped
          if (rx_half) begin
            rx_state <= rx_sync ? SCLU_IDLE : SCLU_DATA;
            rx_bit   <= 3'h0;
          end
        end
        SCLU_DATA: begin
          if (rx_half) begin
            rx_shift <= {rx_sync, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= SCLU_STOP;
            end
          end
        end
        SCLU_STOP: begin
          // bad stop bit discards the character
          if (rx_half) begin
            rx_state <= SCLU_IDLE;
          end
        end
        default: rx_state <= SCLU_IDLE;
      endcase
    end
  end

  // loaded flag, set wins over read
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_data   <= 8'h00;
      rx_loaded <= 1'b0;
    end else if (rx_done) begin
      rx_data   <= rx_shift;
      rx_loaded <= 1'b1;
    end else if (rx_read) begin
      rx_loaded <= 1'b0;
    end
  end

  // ---------------- transmitter
  sclu_state_t tx_state;
  logic [7:0]  tx_hold;
  logic        tx_hold_full;
  logic [7:0]  tx_shift;
  logic [2:0]  tx_bit;
  logic        tx_stop2;
  logic        tx_full;
  logic        tx_take;
  logic        tx_line;

  sclu_bit_timer #(.W(TW)) u_tx_timer (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .restart   (tx_take),
    .period    (period),
    .half_tick (),
    .full_tick (tx_full)
  );

  // shifter pulls from holding buffer when idle
  assign tx_take = (tx_state == SCLU_IDLE) && tx_hold_full;

  // holding buffer load; a write while full overwrites
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_hold      <= 8'h00;
      tx_hold_full <= 1'b0;
    end else if (write_transmit_char) begin
      tx_hold      <= wr_data;
      tx_hold_full <= 1'b1;
    end else if (tx_take) begin
      tx_hold_full <= 1'b0;
    end
  end

  assign tx_empty = !tx_hold_full;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_state <= SCLU_IDLE;
      tx_shift <= 8'h00;
      tx_bit   <= 3'h0;
      tx_stop2 <= 1'b0;
    end else begin
      case (tx_state)
        SCLU_IDLE: begin
          if (tx_take) begin
            tx_shift <= tx_hold;
            tx_state <= SCLU_START;
            tx_bit   <= 3'h0;
            tx_stop2 <= two_stops;
          end
        end
        SCLU_START: begin
          if (tx_full) begin
            tx_state <= SCLU_DATA;
          end
        end
        SCLU_DATA: begin
          if (tx_full) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit   <= tx_bit + 3'h1;
            if (tx_bit == 3'h7) begin
              tx_state <= SCLU_STOP;
            end
          end
        end
        SCLU_STOP: begin
          if (tx_full) begin
            if (tx_stop2) begin
              tx_stop2 <= 1'b0;
            end else begin
              tx_state <= SCLU_IDLE;
            end
          end
        end
        default: tx_state <= SCLU_IDLE;
      endcase
    end
  end

  // low start, data, high stop and idle
  assign tx_line = (tx_state == SCLU_START) ? 1'b0 :
                   (tx_state == SCLU_DATA)  ? tx_shift[0] : sclu_pkg::LINE_IDLE;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      serial_out_plus  <= sclu_pkg::LINE_IDLE;
      serial_out_minus <= ~sclu_pkg::LINE_IDLE;
    end else begin
      serial_out_plus  <= tx_line;
      serial_out_minus <= ~tx_line;
    end
  end

  // ---------------- requests
  logic rx_req;
  logic tx_req;
  assign rx_req = rx_loaded && irq_mask[0];
  assign tx_req = tx_empty && irq_mask[1];

  // receive request, number 4 wins over 5
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      serial_irq <= 1'b0;
      irq_num    <= 3'h0;
      irq_vector <= 16'h0000;
    end else begin
      serial_irq <= (rx_req || tx_req) && !higher_pending;
      irq_num    <= rx_req ? sclu_pkg::IRQ_NUM_RX : sclu_pkg::IRQ_NUM_TX;
      irq_vector <= rx_req ? sclu_pkg::VEC_RX : sclu_pkg::VEC_TX;
    end
  end
endmodule
`default_nettype wire

// ===== dv/sclu_uart_sva.sv
// assertion checker for the current-loop serial block
`timescale 1ns/1ps
`default_nettype none
module sclu_uart_chk (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        write_rate_code,
  input wire logic        write_transmit_char,
  input wire logic [7:0]  wr_data,
  input wire logic        rx_read,
  input wire logic [1:0]  irq_mask,
  input wire logic        higher_pending,
  input wire logic        serial_out_plus,
  input wire logic        serial_out_minus,
  input wire logic        rx_loaded,
  input wire logic        tx_empty,
  input wire logic        serial_irq,
  input wire logic [2:0]  irq_num,
  input wire logic [15:0] irq_vector,
  input wire logic [7:0]  rate_code
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // receive wins, so transmit is judged only when receive is quiet
  wire rx_go = rx_loaded && irq_mask[0] && !higher_pending;
  sequence s_load;
    write_transmit_char ##1 !tx_empty;
  endsequence
  AST_MINUS: assert property (serial_out_minus == !serial_out_plus)
    else $error("minus line not complement");
  AST_RATE: assert property (write_rate_code |=> rate_code == $past(wr_data))
    else $error("rate code not taken");
  AST_TXLOAD: assert property (write_transmit_char |-> s_load)
    else $error("holding buffer not filled");
  AST_RDCLR: assert property (rx_read |=> !rx_loaded)
    else $error("read left loaded flag");
  AST_LOADED: assert property (rx_loaded && !rx_read |=> rx_loaded)
    else $error("loaded flag dropped");
  AST_RXIRQ: assert property (rx_go |=> serial_irq && irq_num == sclu_pkg::IRQ_NUM_RX
    && irq_vector == sclu_pkg::VEC_RX) else $error("receive request wrong");
  AST_TXIRQ: assert property (tx_empty && irq_mask[1] && !higher_pending && !rx_go
    |=> serial_irq && irq_vector == sclu_pkg::VEC_TX) else $error("transmit request wrong");
  AST_BLOCK: assert property (higher_pending || irq_mask == 2'h0 |=> !serial_irq)
    else $error("request not blocked");
endmodule
bind sclu_uart sclu_uart_chk u_chk (.*);
`default_nettype wire

// ===== dv/sclu_term.sv
// behavioural terminal at the far end of the loop
`timescale 1ns/1ps
`default_nettype none
module sclu_term #(
  parameter int P = 16
) (
  input  wire logic core_clk,
  input  wire logic serial_out_plus,
  output var logic  serial_in_plus
);
  logic [7:0] got[$];
  logic [7:0] d;
  initial serial_in_plus = 1'b1;
  task automatic send(input logic [7:0] b);
    @(negedge core_clk);
    serial_in_plus = 1'b0;
    repeat (P) @(negedge core_clk);
    for (int i = 0; i < 8; i++) begin
      serial_in_plus = b[i];
      repeat (P) @(negedge core_clk);
    end
    serial_in_plus = 1'b1;
    repeat (P) @(negedge core_clk);
  endtask
  // mid-bit sampling; bad stop drops char
  initial forever begin
    @(negedge serial_out_plus);
    repeat (P / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (P) @(posedge core_clk);
      d[i] = serial_out_plus;
    end
    repeat (P) @(posedge core_clk);
    if (serial_out_plus === 1'b1) got.push_back(d);
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// self-checking bench for the current-loop serial block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk;
  logic        rst_b = 1'b0;
  logic        write_rate_code = 1'b0;
  logic        write_transmit_char = 1'b0;
  logic        rx_read = 1'b0;
  logic [7:0]  wr_data = 8'h00;
  logic [1:0]  irq_mask = 2'h0;
  logic        higher_pending = 1'b0;
  logic        serial_in_plus, serial_out_plus, rx_loaded, tx_empty, serial_irq;
  logic [7:0]  rx_data, rate_code, b;
  logic [2:0]  irq_num;
  logic [15:0] irq_vector;
  logic [7:0]  q[$];
  int          num_errors, checked, cyc;
  sclu_uart u_dut (.core_clk(core_clk), .rst_b(rst_b), .write_rate_code(write_rate_code),
    .write_transmit_char(write_transmit_char), .wr_data(wr_data), .rx_read(rx_read),
    .irq_mask(irq_mask), .higher_pending(higher_pending), .serial_in_plus(serial_in_plus),
    .serial_out_plus(serial_out_plus), .serial_out_minus(), .rx_data(rx_data),
    .rx_loaded(rx_loaded), .tx_empty(tx_empty), .serial_irq(serial_irq),
    .irq_num(irq_num), .irq_vector(irq_vector), .rate_code(rate_code));
  sclu_term #(.P(16)) u_term (.core_clk(core_clk), .serial_out_plus(serial_out_plus),
    .serial_in_plus(serial_in_plus));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic logic [19:0] exp_irq(input logic rx);
    return rx ? {1'b1, 3'h4, 16'h0020} : {1'b1, 3'h5, 16'h0028};
  endfunction
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse(ref logic s, input logic [7:0] d);
    @(negedge core_clk);
    wr_data = d;
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ceiling well above the few thousand cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(32'h255c));
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    for (int k = 0; k < 5; k++) begin
      b = (k == 4) ? 8'h00 : 8'($urandom);
      pulse(write_rate_code, b);
      chk("rate", 20'(b), 20'(rate_code));
    end
    irq_mask = 2'h2;
    for (int k = 0; k < 8; k++) begin
      b = (k == 0) ? 8'h01 : (k == 1) ? 8'hff : 8'($urandom);
      // two stop bits from here on; bit period stays the same
      if (k == 6) begin
        pulse(write_rate_code, 8'h80);
        chk("rate2", 20'h80, 20'(rate_code));
      end
      while (tx_empty !== 1'b1) @(negedge core_clk);
      @(negedge core_clk);
      chk("txirq", exp_irq(1'b0), {serial_irq, irq_num, irq_vector});
      pulse(write_transmit_char, b);
      q.push_back(b);
    end
    // next char is queued, so a single stop would show its start bit here
    while (u_term.got.size() < 7) @(negedge core_clk);
    repeat (16) @(negedge core_clk);
    chk("stops", 20'h1, 20'(serial_out_plus));
    while (u_term.got.size() < 8) @(negedge core_clk);
    foreach (q[i]) chk("txchar", 20'(q[i]), 20'(u_term.got[i]));
    irq_mask = 2'h0;
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'($urandom);
      u_term.send(b);
      chk("rxchar", 20'({1'b1, b}), 20'({rx_loaded, rx_data}));
      chk("rxmask", 20'h0, 20'(serial_irq));
      irq_mask = 2'h3;
      higher_pending = k[0];
      repeat (2) @(negedge core_clk);
      chk("rxirq", k[0] ? 20'h0 : exp_irq(1'b1),
        k[0] ? 20'(serial_irq) : {serial_irq, irq_num, irq_vector});
      pulse(rx_read, 8'h00);
      chk("rdclr", 20'h0, 20'(rx_loaded));
      irq_mask = 2'h0;
      higher_pending = 1'b0;
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
